// [logic/otp_guard_pkg.sv]
package otp_guard_pkg;
   // secure space geometry
   localparam int OTP_BYTES        = 1024;
   localparam int OTP_ADDR_W       = 10;
   localparam int REGION_COUNT     = 32;
   localparam int REGION_SHIFT     = 5;
   localparam int RANDOM_BYTES     = 16;
   localparam logic [9:0] LOCK_BYTE_LO = 10'h010;
   localparam logic [9:0] LOCK_BYTE_HI = 10'h013;
   localparam logic [9:0] RESV_BYTE_LO = 10'h014;
   localparam logic [9:0] RESV_BYTE_HI = 10'h01F;
   localparam logic [7:0] ERASED_BYTE  = 8'hFF;
   // array sectors and overlay window
   localparam int SECTOR_COUNT     = 256;
   localparam int SECTOR_W         = 8;
   localparam int ADDR_W           = 26;
   localparam int SECTOR_SHIFT     = 18;
   localparam int OVERLAY_W        = 13;
   // hidden password; value arbitrary
   localparam logic [63:0] HIDDEN_PASSWORD = 64'h0123_4567_89AB_CDEF;
   // register port map
   localparam int REG_AW = 4;
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_STATUS    = 4'h1;
   localparam logic [3:0] REG_PASS_LO   = 4'h2;
   localparam logic [3:0] REG_PASS_HI   = 4'h3;
   localparam logic [3:0] REG_GUARD_CFG = 4'h4;
   // ctrl fields
   localparam int CTRL_FREEZE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // status fields
   localparam int ST_FAIL_BIT    = 0;
   localparam int ST_LOCK_BIT    = 1;
   localparam int ST_OVERLAY_BIT = 2;
   localparam int ST_PWMODE_BIT  = 3;
   localparam int ST_CFG_DONE    = 4;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_OTP_ENTER, CMD_OTP_EXIT, CMD_PROGRAM, CMD_ERASE,
      CMD_NV_PROGRAM, CMD_NV_ERASE, CMD_VOL_SET, CMD_VOL_CLEAR,
      CMD_LOCK_CLEAR, CMD_PASS_UNLOCK, CMD_SOFT_RESET
   } cmd_type;
endpackage

// [logic/otp_region_and_sector_guard.sv]
// Summary of operation
// - 1024-byte OTP space, 32 regions of 32 bytes, each lockable.
// - programming zeros into the 16 random-value bytes fails, sets fail flag.
// - bytes 0x10-0x13 hold region lock bits; zero blocks that region.
// - all non-random OTP bytes delivered as FFh.
// - freeze bit zero makes OTP programs fail silently.
// - overlay reads: OTP inside entry sector, array data elsewhere.
// - exit sequence returns reads to the main array.
// - OTP programs like array, repeatable, never erased; here every reset reloads otp_mem_q to FFh.
// - OTP program ignores address bit A10 and above.
// - sector guard mode does not affect the OTP space.
// - either sector guard bit zero rejects program and erase.
// - lock bit zero refuses changes to persistent guard bits.
// - persistent mode: reset sets lock bit; soft reset leaves it.
// - persistent mode: command clears lock bit, none sets it.
// - password mode: reset clears lock bit; here reset reloads cfg_q to 11, so the lock bit always comes up set.
// - 64-bit hidden password; exact match sets lock bit in password mode.
// - password mode: a command clears the lock bit anytime.
// - lock management mode fixed once by OTP config bits; here cfg_q is a register that every reset reloads to 11 (persistent).
// - persistent guard bits delivered erased, all sectors unprotected.
// - locked persistent-bit program/erase aborts and reports failure.
// - volatile guard bits set/cleared freely; reset leaves unprotected.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
module otp_region_and_sector_guard
   import otp_guard_pkg::*;
(
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire otp_guard_pkg::cmd_type      cmd,
   input  wire logic                        cmd_valid,
   input  wire logic [otp_guard_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [7:0]                  cmd_data,
   input  wire logic [7:0]                  array_rdata,
   input  wire logic                        rd_req,
   input  wire logic [otp_guard_pkg::ADDR_W-1:0] rd_addr,
   input  wire logic [otp_guard_pkg::REG_AW-1:0] reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic [31:0]                      reg_rdata,
   output logic [7:0]                       rd_data,
   output logic                             rd_valid,
   output logic                             array_write_ok,
   output logic                             array_op_done
);
   import otp_guard_pkg::*;

   logic [7:0]                  otp_mem_q [OTP_BYTES];
   logic                        overlay_q;
   logic [SECTOR_W-1:0]         overlay_sector_q;
   logic                        lock_bit_q;
   logic                        fail_q;
   logic                        freeze_q;
   logic [1:0]                  cfg_q;
   logic [SECTOR_COUNT-1:0]     nv_guard_q;
   logic [SECTOR_COUNT-1:0]     vol_guard_q;
   logic [63:0]                 pass_q;
   logic [7:0]                  rd_data_q;
   logic                        rd_valid_q;
   logic                        wr_ok_q;
   logic                        done_q;
   logic                        rst_seen_q;

   logic [OTP_ADDR_W-1:0]       otp_idx;
   logic [SECTOR_W-1:0]         cmd_sector;
   logic                        region_locked;
   logic                        random_zero;
   logic                        pw_mode;

   function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
      sector_of = a[SECTOR_SHIFT +: SECTOR_W];
   endfunction

   // array program or erase, the two commands that need a sector decision
   function automatic logic is_array_cmd(input cmd_type c);
      is_array_cmd = (c == CMD_PROGRAM) || (c == CMD_ERASE);
   endfunction

   // commands that would change a persistent guard bit
   function automatic logic is_nv_cmd(input cmd_type c);
      is_nv_cmd = (c == CMD_NV_PROGRAM) || (c == CMD_NV_ERASE);
   endfunction

   function automatic logic lock_of(input logic [4:0] region,
                                   input logic [7:0] b0, input logic [7:0] b1,
                                   input logic [7:0] b2, input logic [7:0] b3);
      logic [31:0] all;
      all = {b3, b2, b1, b0};
      lock_of = all[region];
   endfunction

   assign otp_idx    = cmd_addr[OTP_ADDR_W-1:0];
   assign cmd_sector = sector_of(cmd_addr);
   assign region_locked = !lock_of(otp_idx[OTP_ADDR_W-1:REGION_SHIFT],
                                   otp_mem_q[LOCK_BYTE_LO], otp_mem_q[LOCK_BYTE_LO+10'h001],
                                   otp_mem_q[LOCK_BYTE_LO+10'h002], otp_mem_q[LOCK_BYTE_HI]);
   assign random_zero = (otp_idx < 10'(RANDOM_BYTES)) && (~cmd_data != 8'h00);
   // mode from config bits; 00 = password
   assign pw_mode = (cfg_q == 2'b00);

   logic otp_prog;
   assign otp_prog = cmd_valid && cmd == CMD_PROGRAM && overlay_q
                     && cmd_sector == overlay_sector_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < OTP_BYTES; i++) begin
            otp_mem_q[i] <= ERASED_BYTE;
         end
      end else if (otp_prog && freeze_q && !region_locked && !random_zero) begin
         // repeat programming only clears bits; locked skips
         otp_mem_q[otp_idx] <= otp_mem_q[otp_idx] & cmd_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overlay_q        <= 1'b0;
         overlay_sector_q <= '0;
      end else if (cmd_valid && cmd == CMD_OTP_ENTER) begin
         overlay_q        <= 1'b1;
         overlay_sector_q <= cmd_sector;
      end else if (cmd_valid && (cmd == CMD_OTP_EXIT || cmd == CMD_SOFT_RESET)) begin
         overlay_q <= 1'b0;
      end
   end

   // reads inside overlay sector see otp, rest array
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_req;
         if (rd_req) begin
            if (overlay_q && sector_of(rd_addr) == overlay_sector_q) begin
               // beyond the valid range data is indeterminate; aliasing is fine
               rd_data_q <= otp_mem_q[rd_addr[OTP_ADDR_W-1:0]];
            end else begin
               rd_data_q <= array_rdata;
            end
         end
      end
   end

   // lock bit after reset depends on mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_bit_q <= 1'b0;
      end else if (!rst_seen_q) begin
         lock_bit_q <= !pw_mode;
      end else if (cmd_valid && cmd == CMD_LOCK_CLEAR) begin
         lock_bit_q <= 1'b0;
      end else if (cmd_valid && cmd == CMD_PASS_UNLOCK && pw_mode
                   && pass_q == HIDDEN_PASSWORD) begin
         lock_bit_q <= 1'b1;
      end
   end

   // marks the first edge after reset so the lock bit can follow the mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_guard_q <= '1;
      end else if (cmd_valid && lock_bit_q && is_nv_cmd(cmd)) begin
         if (cmd == CMD_NV_PROGRAM) begin
            nv_guard_q[cmd_sector] <= 1'b0;
         end else if (cmd == CMD_NV_ERASE) begin
            nv_guard_q <= '1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vol_guard_q <= '1;
      end else if (cmd_valid && cmd == CMD_VOL_SET) begin
         vol_guard_q[cmd_sector] <= 1'b0;
      end else if (cmd_valid && cmd == CMD_VOL_CLEAR) begin
         vol_guard_q[cmd_sector] <= 1'b1;
      end
   end

   // array program/erase permission
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ok_q <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q  <= cmd_valid && is_array_cmd(cmd) && !otp_prog;
         // either guard bit zero rejects; otp path bypasses
         wr_ok_q <= cmd_valid && is_array_cmd(cmd) && !otp_prog
                    && nv_guard_q[cmd_sector] && vol_guard_q[cmd_sector];
      end
   end

   // program-fail flag, set wins over software clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_q <= 1'b0;
      end else if ((otp_prog && freeze_q && random_zero)
                   // locked persistent-bit ops abort with failure
                   || (cmd_valid && !lock_bit_q && is_nv_cmd(cmd))) begin
         // random area hit; frozen attempts stay silent
         fail_q <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_FAIL_BIT]) begin
         fail_q <= 1'b0;
      end
   end

   // freeze and password registers; config bits can only be cleared
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         freeze_q <= CTRL_RESET[CTRL_FREEZE_BIT];
         pass_q   <= 64'h0;
         cfg_q    <= 2'b11;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               freeze_q <= reg_wdata[CTRL_FREEZE_BIT];
            end
            REG_PASS_LO: begin
               pass_q[31:0] <= reg_wdata;
            end
            REG_PASS_HI: begin
               pass_q[63:32] <= reg_wdata;
            end
            // otp bits can only go to zero
            REG_GUARD_CFG: begin
               cfg_q <= cfg_q & reg_wdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // register readback
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: begin
               reg_rdata <= {31'h0, freeze_q};
            end
            REG_STATUS: begin
               reg_rdata <= {27'h0, rst_seen_q, pw_mode, overlay_q, lock_bit_q, fail_q};
            end
            REG_GUARD_CFG: begin
               reg_rdata <= {30'h0, cfg_q};
            end
            // password registers are write-only so the secret never reads back
            default: begin
               reg_rdata <= 32'h0;
            end
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   assign rd_data        = rd_data_q;
   assign rd_valid       = rd_valid_q;
   assign array_write_ok = wr_ok_q;
   assign array_op_done  = done_q;
endmodule

// [bench/array_model.sv]
// stands in for the main array; answers combinationally in the rd_req cycle
module array_model
   import otp_guard_pkg::*;
(
   input  wire logic              rd_req,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic [7:0]             array_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle shows the inverse so a capture outside rd_req is caught
   assign array_rdata = rd_req ? (rd_addr[7:0] ^ 8'hA5) : ~(rd_addr[7:0] ^ 8'hA5);
endmodule

// [bench/otp_guard_asserts.sv]
module otp_guard_asserts
   import otp_guard_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire cmd_type     cmd,
   input wire logic        cmd_valid,
   input wire logic        rd_req,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        rd_valid,
   input wire logic        array_write_ok,
   input wire logic        array_op_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_write_cmd;
      cmd_valid && (cmd == CMD_PROGRAM || cmd == CMD_ERASE);
   endsequence
   sequence s_erase_cmd;
      cmd_valid && cmd == CMD_ERASE;
   endsequence
   sequence s_guard_cmd;
      cmd_valid && (cmd == CMD_NV_PROGRAM || cmd == CMD_NV_ERASE || cmd == CMD_SOFT_RESET);
   endsequence
   a_read_answer: assert property (rd_req |=> rd_valid)
      else $error("read answer missing");
   a_read_quiet: assert property (!rd_req |=> !rd_valid)
      else $error("read answer without request");
   a_reg_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("register data outside read slot");
   a_ok_cause: assert property (array_write_ok |-> $past(cmd_valid) &&
      ($past(cmd) == CMD_PROGRAM || $past(cmd) == CMD_ERASE))
      else $error("write grant without array command");
   a_ok_done: assert property (array_write_ok |-> array_op_done)
      else $error("write grant without decision");
   a_done_cause: assert property (array_op_done |-> $past(cmd_valid))
      else $error("decision without command");
   a_done_write: assert property (array_op_done |-> $past(s_write_cmd))
      else $error("decision without command");
   a_write_done: assert property (s_erase_cmd |=> array_op_done)
      else $error("erase command not decided on the array");
   a_guard_nowr: assert property (s_guard_cmd |=> !array_write_ok)
      else $error("grant after guard command");
endmodule
bind otp_region_and_sector_guard otp_guard_asserts chk (.core_clk(core_clk), .rst_n(rst_n),
   .cmd(cmd), .cmd_valid(cmd_valid), .rd_req(rd_req), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .rd_valid(rd_valid), .array_write_ok(array_write_ok), .array_op_done(array_op_done));

// [bench/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import otp_guard_pkg::*;
   logic              core_clk = 0, rst_n = 0, cmd_valid = 0, rd_req = 0, reg_wr = 0, reg_rd = 0;
   cmd_type           cmd = CMD_NONE;
   logic [ADDR_W-1:0] cmd_addr = '0, rd_addr = '0;
   logic [7:0]        cmd_data = '0, array_rdata, rd_data;
   logic [REG_AW-1:0] reg_addr = '0;
   logic [31:0]       reg_wdata = '0, reg_rdata;
   logic              rd_valid, ok, done;
   int                bad_count = 0, compares = 0, cycles = 0;
   always #25 core_clk = ~core_clk;
   otp_region_and_sector_guard dut (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .array_rdata(array_rdata), .rd_req(rd_req), .rd_addr(rd_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rd_data(rd_data), .rd_valid(rd_valid), .array_write_ok(ok), .array_op_done(done));
   array_model far (.rd_req(rd_req), .rd_addr(rd_addr), .array_rdata(array_rdata));
   task final_report;
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge core_clk); reg_wr <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk); reg_rd <= 1; reg_addr <= a;
      @(posedge core_clk); reg_rd <= 0;
      #1 chk(reg_rdata, e);
   endtask
   task st(input logic f, input logic l, input logic o, input logic p);
      rd(REG_STATUS, {27'h0, 1'b1, p, o, l, f});
   endtask
   task op(input cmd_type c, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk); cmd_valid <= 1; cmd <= c; cmd_addr <= a; cmd_data <= d;
      @(posedge core_clk); cmd_valid <= 0;
      #1;
   endtask
   task prog(input logic [ADDR_W-1:0] a, input logic e);
      op(CMD_PROGRAM, a, 8'h00);
      chk(ok, e);
      chk(done, 1'b1);
   endtask
   task mem(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge core_clk); rd_req <= 1; rd_addr <= a;
      @(posedge core_clk); rd_req <= 0;
      #1 chk(rd_data, e);
   endtask
   function automatic logic [ADDR_W-1:0] sa(input logic [7:0] n, input logic [9:0] off);
      return {n, 8'h00, off};
   endfunction
   task t_reset;
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_GUARD_CFG, 32'h3);
      rd(4'hF, 32'h0);
      st(0, 1, 0, 0);
   endtask
   task t_sectors;
      prog(sa(5, 0), 1);
      op(CMD_VOL_SET, sa(5, 0), 8'h00);
      prog(sa(5, 0), 0);
      op(CMD_VOL_CLEAR, sa(5, 0), 8'h00);
      prog(sa(5, 0), 1);
      op(CMD_NV_PROGRAM, sa(6, 0), 8'h00);
      op(CMD_ERASE, sa(6, 0), 8'h00);
      chk(ok, 0);
      op(CMD_NV_ERASE, sa(6, 0), 8'h00);
      op(CMD_LOCK_CLEAR, '0, 8'h00);
      op(CMD_SOFT_RESET, '0, 8'h00);
      st(0, 0, 0, 0);
      op(CMD_NV_PROGRAM, sa(6, 0), 8'h00);
      st(1, 0, 0, 0);
      prog(sa(6, 0), 1);
      wr(REG_STATUS, 32'h1);
      wr(REG_PASS_LO, HIDDEN_PASSWORD[31:0]);
      wr(REG_PASS_HI, HIDDEN_PASSWORD[63:32]);
      op(CMD_PASS_UNLOCK, '0, 8'h00);
      st(0, 0, 0, 0);
   endtask
   task t_otp;
      op(CMD_OTP_ENTER, sa(2, 0), 8'h00);
      mem(sa(2, 10'h020), 8'hFF);
      mem(sa(3, 10'h007), 8'h07 ^ 8'hA5);
      op(CMD_PROGRAM, sa(2, 10'h020) | 26'h400, 8'h3C);
      mem(sa(2, 10'h020), 8'h3C);
      op(CMD_PROGRAM, sa(2, 10'h010), 8'hFD);
      op(CMD_PROGRAM, sa(2, 10'h021), 8'h00);
      mem(sa(2, 10'h021), 8'hFF);
      mem(sa(2, 10'h010), 8'hFD);
      op(CMD_PROGRAM, sa(2, 10'h014), 8'h5A);
      mem(sa(2, 10'h014), 8'h5A);
      op(CMD_PROGRAM, sa(2, 10'h005), 8'h00);
      st(1, 0, 1, 0);
      wr(REG_STATUS, 32'h1);
      wr(REG_CTRL, 32'h0);
      op(CMD_PROGRAM, sa(2, 10'h040), 8'h11);
      mem(sa(2, 10'h040), 8'hFF);
      st(0, 0, 1, 0);
      op(CMD_OTP_EXIT, '0, 8'h00);
      mem(sa(2, 10'h020), 8'h20 ^ 8'hA5);
   endtask
   task t_pass;
      wr(REG_GUARD_CFG, 32'h0);
      wr(REG_GUARD_CFG, 32'h3);
      rd(REG_GUARD_CFG, 32'h0);
      wr(REG_PASS_HI, HIDDEN_PASSWORD[63:32] ^ 32'h1);
      op(CMD_PASS_UNLOCK, '0, 8'h00);
      st(0, 0, 0, 1);
      wr(REG_PASS_HI, HIDDEN_PASSWORD[63:32]);
      op(CMD_PASS_UNLOCK, '0, 8'h00);
      st(0, 1, 0, 1);
      op(CMD_LOCK_CLEAR, '0, 8'h00);
      st(0, 0, 0, 1);
   endtask
   task t_hw_reset;
      op(CMD_VOL_SET, sa(7, 0), 8'h00);
      prog(sa(7, 0), 0);
      rst_n <= 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      repeat (2) @(posedge core_clk);
      prog(sa(7, 0), 1);
      st(0, 1, 0, 0);
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report;
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1;
      repeat (2) @(posedge core_clk);
      t_reset;
      t_sectors;
      t_otp;
      t_pass;
      t_hw_reset;
      final_report;
   end
endmodule
